//--- pcrm_pkg.sv
package pcrm_pkg;

   // ************************************************************
   // address space
   // ************************************************************
   localparam int ADDR_W = 8;
   localparam int BANK_BYTES = 56;
   localparam logic [7:0] ADDR_LAST = 8'h37;
   localparam logic [7:0] ADDR_RSVD_LAST = 8'h03;

   // register base offsets, most significant byte first
   localparam logic [7:0] OFS_ENV2 = 8'h04;
   localparam logic [7:0] OFS_ENV1 = 8'h08;
   localparam logic [7:0] OFS_DECEL_SCURVE = 8'h0c;
   localparam logic [7:0] OFS_ACCEL_SCURVE = 8'h0e;
   localparam logic [7:0] OFS_DECEL_RATE = 8'h10;
   localparam logic [7:0] OFS_ACCEL_RATE = 8'h12;
   localparam logic [7:0] OFS_SPEED_MAG = 8'h14;
   localparam logic [7:0] OFS_RAMP_DOWN = 8'h16;
   localparam logic [7:0] OFS_INIT_SPEED = 8'h19;
   localparam logic [7:0] OFS_RUN_SPEED_A = 8'h1b;
   localparam logic [7:0] OFS_RUN_SPEED_B = 8'h1d;
   localparam logic [7:0] OFS_PULSE_TARGET = 8'h1f;
   localparam logic [7:0] OFS_OP_MODE = 8'h23;
   localparam logic [7:0] OFS_COMMAND = 8'h25;
   localparam logic [7:0] OFS_STATUS = 8'h26;
   localparam logic [7:0] OFS_INT_CAUSE = 8'h2a;
   localparam logic [7:0] OFS_GPIO_CTRL = 8'h2c;
   localparam logic [7:0] OFS_POSITION = 8'h2e;
   localparam logic [7:0] OFS_REMAINING = 8'h32;
   localparam logic [7:0] OFS_SPEED_MON = 8'h36;

   // ************************************************************
   // field widths and reset
   // ************************************************************
   localparam int W_ENV1 = 30;
   localparam int W_SCURVE = 12;
   localparam int W_RATE = 16;
   localparam int W_MAG = 12;
   localparam int W_RAMP = 24;
   localparam int W_SPEED = 13;
   localparam int W_PULSE = 28;
   localparam int W_MODE = 15;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // speed change commands (codes are arbitrary)
   localparam logic [7:0] CMD_RUN_SPEED_A = 8'h40;
   localparam logic [7:0] CMD_RUN_SPEED_B = 8'h41;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef struct packed {
      logic start;
      logic [ADDR_W-1:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } pcrm_req_t;

   typedef struct packed {
      logic [31:0] status_word;
      logic [W_PULSE-1:0] remaining_pulses;
      logic [W_SPEED-1:0] current_speed;
   } pcrm_mon_t;

   typedef struct packed {
      logic [31:0] env2;
      logic [W_ENV1-1:0] env1;
      logic [W_SCURVE-1:0] decel_scurve_range;
      logic [W_SCURVE-1:0] accel_scurve_range;
      logic [W_RATE-1:0] decel_rate;
      logic [W_RATE-1:0] accel_rate;
      logic [W_MAG-1:0] speed_mag;
      logic [W_RAMP-1:0] ramp_down_point;
      logic [W_SPEED-1:0] initial_speed;
      logic [W_SPEED-1:0] run_speed_step_a;
      logic [W_SPEED-1:0] run_speed_step_b;
      logic [W_PULSE-1:0] pulse_count_target;
      logic [W_MODE-1:0] operation_mode;
      logic [15:0] interrupt_cause;
      logic [15:0] gpio_ctrl;
      logic [31:0] position;
   } pcrm_cfg_t;

   // ************************************************************
   // byte decoding
   // ************************************************************
   // valid bits of one byte address; unused upper bits read zero
   function automatic logic [7:0] byte_mask(input logic [7:0] a);
      logic [7:0] m;
      m = 8'hff;
      if (a <= ADDR_RSVD_LAST || a > ADDR_LAST) begin
         m = 8'h00;
      end else if (a == OFS_ENV1) begin
         m = 8'h3f;
      end else if (a == OFS_DECEL_SCURVE || a == OFS_ACCEL_SCURVE || a == OFS_SPEED_MAG) begin
         m = 8'h0f;
      end else if (a == OFS_INIT_SPEED || a == OFS_RUN_SPEED_A || a == OFS_RUN_SPEED_B) begin
         m = 8'h1f;
      end else if (a == OFS_SPEED_MON) begin
         m = 8'h1f;
      end else if (a == OFS_PULSE_TARGET || a == OFS_REMAINING) begin
         m = 8'h0f;
      end else if (a == OFS_OP_MODE) begin
         m = 8'h7f;
      end
      return m;
   endfunction

   // byte addresses that the host may change
   function automatic logic byte_writable(input logic [7:0] a);
      logic w;
      w = (a > ADDR_RSVD_LAST) && (a < OFS_STATUS);
      if (a >= OFS_INT_CAUSE && a < OFS_REMAINING) begin
         w = 1'b1;
      end
      return w;
   endfunction

endpackage

//--- pcrm_addr_seq.sv
`timescale 1ns/100ps
module pcrm_addr_seq
   import pcrm_pkg::*;
(
   // clock and control
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   // pointer load and step
   input wire logic load,
   input wire logic [ADDR_W-1:0] load_addr,
   input wire logic step,
   // current byte address
   output logic [ADDR_W-1:0] ptr
);

   typedef struct packed {
      logic [ADDR_W-1:0] ptr;
   } pcrm_seq_state_t;

   pcrm_seq_state_t state;
   pcrm_seq_state_t next_state;

   // load wins over step; step advances one byte
   always_comb begin
      next_state = state;
      if (load) begin
         next_state.ptr = load_addr;
      end else if (step) begin
         next_state.ptr = state.ptr + 8'h01;
      end
   end

   // pointer register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= '0;
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign ptr = state.ptr;

endmodule

//--- pcrm_speed_sel.sv
`timescale 1ns/100ps
module pcrm_speed_sel
   import pcrm_pkg::*;
(
   // clock and control
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   // command strobe and code
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   // both run speed step values
   input wire logic [W_SPEED-1:0] speed_a,
   input wire logic [W_SPEED-1:0] speed_b,
   // selected run speed
   output logic sel_b,
   output logic [W_SPEED-1:0] run_speed
);

   typedef struct packed {
      logic sel_b;
      logic [W_SPEED-1:0] run_speed;
   } pcrm_sel_state_t;

   pcrm_sel_state_t state;
   pcrm_sel_state_t next_state;

   // switch source on speed change command, follow selected value
   always_comb begin
      next_state = state;
      if (cmd_valid && cmd_code == CMD_RUN_SPEED_B) begin
         next_state.sel_b = 1'b1;
      end else if (cmd_valid && cmd_code == CMD_RUN_SPEED_A) begin
         next_state.sel_b = 1'b0;
      end
      next_state.run_speed = next_state.sel_b ? speed_b : speed_a;
   end

   // selection register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= '0;
      end else if (ce) begin
         state <= next_state;
      end
   end

   assign sel_b = state.sel_b;
   assign run_speed = state.run_speed;

endmodule

//--- pcrm_regmap.sv
`timescale 1ns/100ps
module pcrm_regmap
   import pcrm_pkg::*;
(
   // clock and control
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   // host byte access
   input wire pcrm_req_t req,
   output logic [7:0] rdata,
   output logic rvalid,
   output logic [ADDR_W-1:0] cur_addr,
   // motion core monitors
   input wire pcrm_mon_t mon,
   // configuration to motion core
   output pcrm_cfg_t cfg,
   output logic [W_SPEED-1:0] active_run_speed,
   output logic run_speed_sel_b,
   // command strobe
   output logic cmd_valid,
   output logic [7:0] cmd_code,
   // host write to read-only byte, or any access to reserved or unmapped byte, seen
   output logic access_fault
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [BANK_BYTES-1:0][7:0] bank;
      logic [7:0] rdata;
      logic rvalid;
      logic cmd_valid;
      logic [7:0] cmd_code;
      logic access_fault;
   } pcrm_state_t;

   pcrm_state_t state;
   pcrm_state_t next_state;

   logic [ADDR_W-1:0] ptr;
   logic [ADDR_W-1:0] acc_addr;
   logic [ADDR_W-1:0] start_next;
   logic access;
   logic [7:0] mon_byte;
   logic [31:0] mon_status;
   logic [31:0] mon_remaining;
   logic [15:0] mon_speed;

   // ************************************************************
   // address sequencing
   // ************************************************************
   // a start carries its own address, later strobes use the pointer
   assign acc_addr = req.start ? req.addr : ptr;
   assign access = req.wr || req.rd;
   // a start with an access leaves the pointer one past its own address
   assign start_next = access ? ADDR_W'(req.addr + 8'h01) : req.addr;

   // every start reloads, so a stale pointer never leaks into a new block
   pcrm_addr_seq u_addr_seq (
      .core_clk (core_clk),
      .srst (srst),
      .ce (ce),
      .load (req.start),
      .load_addr (start_next),
      .step (access),
      .ptr (ptr)
   );

   // ************************************************************
   // byte helpers
   // ************************************************************
   // fetch big-endian bytes from the bank
   function automatic logic [31:0] be_word(input logic [BANK_BYTES-1:0][7:0] b,
                                           input logic [7:0] ofs,
                                           input int nbytes);
      logic [31:0] w;
      w = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         if (i < nbytes) begin
            w = {w[23:0], b[ofs + 8'(i)]};
         end
      end
      return w;
   endfunction

   // pick one byte of a monitor word, most significant first
   function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] idx);
      logic [7:0] r;
      case (idx)
         2'd0: r = w[31:24];
         2'd1: r = w[23:16];
         2'd2: r = w[15:8];
         default: r = w[7:0];
      endcase
      return r;
   endfunction

   // ************************************************************
   // read-only monitor bytes
   // ************************************************************
   // live values from the motion core, padded with zero above width
   always_comb begin
      mon_status = mon.status_word;
      mon_remaining = {4'h0, mon.remaining_pulses};
      mon_speed = {3'h0, mon.current_speed};
      mon_byte = 8'h00;
      if (acc_addr >= OFS_STATUS && acc_addr < OFS_INT_CAUSE) begin
         mon_byte = word_byte(mon_status, 2'(acc_addr - OFS_STATUS));
      end else if (acc_addr >= OFS_REMAINING && acc_addr < OFS_SPEED_MON) begin
         mon_byte = word_byte(mon_remaining, 2'(acc_addr - OFS_REMAINING));
      end else if (acc_addr == OFS_SPEED_MON) begin
         mon_byte = mon_speed[15:8];
      end else if (acc_addr == OFS_SPEED_MON + 8'h01) begin
         mon_byte = mon_speed[7:0];
      end
   end

   // ************************************************************
   // next state
   // ************************************************************
   // byte writes, reads, command strobe and fault flag
   always_comb begin
      next_state = state;
      next_state.rvalid = 1'b0;
      next_state.cmd_valid = 1'b0;
      if (req.wr) begin
         if (byte_writable(acc_addr)) begin
            // one byte only, neighbours of a wide register stay put
            next_state.bank[acc_addr[5:0]] = req.wdata & byte_mask(acc_addr);
            if (acc_addr == OFS_COMMAND) begin
               next_state.cmd_valid = 1'b1;
               next_state.cmd_code = req.wdata;
            end
         end else begin
            // reserved, read-only or unmapped byte: dropped
            next_state.access_fault = 1'b1;
         end
      end
      if (req.rd) begin
         next_state.rvalid = 1'b1;
         if (acc_addr <= ADDR_RSVD_LAST || acc_addr > ADDR_LAST) begin
            next_state.rdata = 8'h00;
            next_state.access_fault = 1'b1;
         end else if (byte_writable(acc_addr)) begin
            next_state.rdata = state.bank[acc_addr[5:0]] & byte_mask(acc_addr);
         end else begin
            next_state.rdata = mon_byte & byte_mask(acc_addr);
         end
      end
      // a start without access clears the fault flag
      if (req.start && !access) begin
         next_state.access_fault = 1'b0;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   // single state register, frozen while ce is low
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state <= '0;
      end else if (ce) begin
         state <= next_state;
      end
   end

   // ************************************************************
   // speed selection
   // ************************************************************
   pcrm_speed_sel u_speed_sel (
      .core_clk (core_clk),
      .srst (srst),
      .ce (ce),
      .cmd_valid (state.cmd_valid),
      .cmd_code (state.cmd_code),
      .speed_a (cfg.run_speed_step_a),
      .speed_b (cfg.run_speed_step_b),
      .sel_b (run_speed_sel_b),
      .run_speed (active_run_speed)
   );

   // ************************************************************
   // outputs
   // ************************************************************
   // configuration fields gathered from the bank
   always_comb begin
      cfg.env2 = be_word(state.bank, OFS_ENV2, 4);
      cfg.env1 = W_ENV1'(be_word(state.bank, OFS_ENV1, 4));
      cfg.decel_scurve_range = W_SCURVE'(be_word(state.bank, OFS_DECEL_SCURVE, 2));
      cfg.accel_scurve_range = W_SCURVE'(be_word(state.bank, OFS_ACCEL_SCURVE, 2));
      cfg.decel_rate = W_RATE'(be_word(state.bank, OFS_DECEL_RATE, 2));
      cfg.accel_rate = W_RATE'(be_word(state.bank, OFS_ACCEL_RATE, 2));
      cfg.speed_mag = W_MAG'(be_word(state.bank, OFS_SPEED_MAG, 2));
      cfg.ramp_down_point = W_RAMP'(be_word(state.bank, OFS_RAMP_DOWN, 3));
      cfg.initial_speed = W_SPEED'(be_word(state.bank, OFS_INIT_SPEED, 2));
      cfg.run_speed_step_a = W_SPEED'(be_word(state.bank, OFS_RUN_SPEED_A, 2));
      cfg.run_speed_step_b = W_SPEED'(be_word(state.bank, OFS_RUN_SPEED_B, 2));
      cfg.pulse_count_target = W_PULSE'(be_word(state.bank, OFS_PULSE_TARGET, 4));
      cfg.operation_mode = W_MODE'(be_word(state.bank, OFS_OP_MODE, 2));
      cfg.interrupt_cause = 16'(be_word(state.bank, OFS_INT_CAUSE, 2));
      cfg.gpio_ctrl = 16'(be_word(state.bank, OFS_GPIO_CTRL, 2));
      cfg.position = be_word(state.bank, OFS_POSITION, 4);
   end

   assign rdata = state.rdata;
   assign rvalid = state.rvalid;
   assign cur_addr = ptr;
   assign cmd_valid = state.cmd_valid;
   assign cmd_code = state.cmd_code;
   assign access_fault = state.access_fault;

endmodule

//--- pcrm_regmap_props.sv
`timescale 1ns/100ps
module pcrm_regmap_props
   import pcrm_pkg::*;
(
   // clock and control
   input wire logic core_clk,
   input wire logic srst,
   input wire logic ce,
   // host side
   input wire pcrm_req_t req,
   input wire logic [7:0] rdata,
   input wire logic rvalid,
   input wire logic [ADDR_W-1:0] cur_addr,
   // core side
   input wire pcrm_mon_t mon,
   input wire pcrm_cfg_t cfg,
   input wire logic [W_SPEED-1:0] active_run_speed,
   input wire logic run_speed_sel_b,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_code,
   input wire logic access_fault
);
   // ******
   // byte access checks
   // ******
   default clocking dc @(posedge core_clk);
   endclocking
   default disable iff (srst);
   // address and strobes of this cycle
   logic [7:0] ea;
   logic wt;
   logic rt;
   assign ea = req.start ? req.addr : cur_addr;
   assign wt = ce && req.wr;
   assign rt = ce && req.rd;
   property p_answer;
      rt |=> rvalid;
   endproperty
   a_answer: assert property (p_answer) else $error("read not answered");
   property p_step;
      (wt || rt) |=> cur_addr == 8'($past(ea) + 8'h01);
   endproperty
   a_step: assert property (p_step) else $error("pointer did not step");
   property p_target;
      wt && ea == OFS_PULSE_TARGET |=> cfg.pulse_count_target[27:24] == $past(req.wdata[3:0]);
   endproperty
   a_target: assert property (p_target) else $error("target top byte");
   property p_one_byte;
      wt && ea == 8'h20 |=> $stable(cfg.pulse_count_target[27:24])
         && $stable(cfg.pulse_count_target[15:0]);
   endproperty
   a_one_byte: assert property (p_one_byte) else $error("other bytes moved");
   property p_remain;
      rt && ea == OFS_REMAINING |=> rdata == {4'h0, $past(mon.remaining_pulses[27:24])};
   endproperty
   a_remain: assert property (p_remain) else $error("remaining read");
   property p_rsvd;
      rt && ea <= ADDR_RSVD_LAST |=> rdata == 8'h00 && access_fault;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved read");
   property p_decel;
      wt && ea == OFS_DECEL_SCURVE |=> cfg.decel_scurve_range[11:8] == $past(req.wdata[3:0]);
   endproperty
   a_decel: assert property (p_decel) else $error("decel range");
   property p_sel_b;
      wt && ea == OFS_COMMAND && req.wdata == CMD_RUN_SPEED_B ##1 ce
         |=> run_speed_sel_b && active_run_speed == cfg.run_speed_step_b;
   endproperty
   a_sel_b: assert property (p_sel_b) else $error("speed b not selected");
   property p_cmd;
      wt && ea == OFS_COMMAND |=> cmd_valid && cmd_code == $past(req.wdata);
   endproperty
   a_cmd: assert property (p_cmd) else $error("command not strobed");
endmodule

bind pcrm_regmap pcrm_regmap_props u_pcrm_regmap_props (
   .core_clk(core_clk), .srst(srst), .ce(ce), .req(req), .rdata(rdata),
   .rvalid(rvalid), .cur_addr(cur_addr), .mon(mon), .cfg(cfg),
   .active_run_speed(active_run_speed), .run_speed_sel_b(run_speed_sel_b),
   .cmd_valid(cmd_valid), .cmd_code(cmd_code), .access_fault(access_fault));

//--- pcrm_host.sv
`timescale 1ns/100ps
module pcrm_host
   import pcrm_pkg::*;
(
   // clock
   input wire logic core_clk,
   // byte request
   output pcrm_req_t req,
   // read answer
   input wire logic [7:0] rdata,
   input wire logic rvalid
);
   // ******
   // host byte transfers
   // ******
   initial begin
      req = '0;
   end
   // one request, launched just after an edge
   task automatic put(input pcrm_req_t r);
      @(posedge core_clk);
      req <= r;
   endtask
   // released lines invert so stale values never match
   task automatic idle();
      @(posedge core_clk);
      req <= '{1'b0, ~req.addr, 1'b0, 1'b0, ~req.wdata};
   endtask
   // block from one start address, one byte per edge
   task automatic block(input logic [7:0] a, input logic w, input logic [7:0] d[$],
                        input int n, output logic [8:0] q[$]);
      q = {};
      for (int i = 0; i < n + 2; i++) begin
         if (i < n) begin
            put('{i == 0, a, w, !w, w ? d[i] : a});
         end else if (i == n) begin
            idle();
         end else begin
            @(posedge core_clk);
         end
         if (i > 1 && !w) begin
            q.push_back({rvalid, rdata});
         end
      end
   endtask
   // idle run speed first, then the switch command
   task automatic change_speed(input logic [12:0] v, input logic [7:0] c);
      logic [8:0] q[$];
      logic [7:0] d[$];
      d.push_back({3'h0, v[12:8]});
      d.push_back(v[7:0]);
      block(c == CMD_RUN_SPEED_B ? OFS_RUN_SPEED_B : OFS_RUN_SPEED_A, 1'b1, d, 2, q);
      d = {};
      d.push_back(c);
      block(OFS_COMMAND, 1'b1, d, 1, q);
   endtask
endmodule

//--- test_pcrm_regmap.sv
`timescale 1ns/100ps
module test_pcrm_regmap
   import pcrm_pkg::*;
();
   logic core_clk;
   logic srst;
   logic ce;
   pcrm_req_t req;
   pcrm_mon_t mon;
   pcrm_cfg_t cfg;
   logic [7:0] rdata;
   logic rvalid;
   logic [7:0] cur_addr;
   logic [12:0] active_run_speed;
   logic run_speed_sel_b;
   logic cmd_valid;
   logic [7:0] cmd_code;
   logic access_fault;
   int bad_count;
   int comparisons;
   logic [7:0] mem [0:63];
   logic [7:0] d[$];
   logic [8:0] q[$];
   // device and host model
   pcrm_regmap u_pcrm_regmap (.core_clk(core_clk), .srst(srst), .ce(ce), .req(req),
      .rdata(rdata), .rvalid(rvalid), .cur_addr(cur_addr), .mon(mon), .cfg(cfg),
      .active_run_speed(active_run_speed), .run_speed_sel_b(run_speed_sel_b),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .access_fault(access_fault));
   pcrm_host u_pcrm_host (.core_clk(core_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
   // valid bits of each byte
   function automatic logic [7:0] vmask(input logic [7:0] a);
      case (a)
         8'h08: return 8'h3f;
         8'h0c, 8'h0e, 8'h14, 8'h1f, 8'h32: return 8'h0f;
         8'h19, 8'h1b, 8'h1d, 8'h36: return 8'h1f;
         8'h23: return 8'h7f;
         default: return (a > 8'h03 && a < 8'h38) ? 8'hff : 8'h00;
      endcase
   endfunction
   // expected byte on a read
   function automatic logic [7:0] expb(input logic [7:0] a);
      logic [143:0] ro;
      ro = {mon.status_word, 64'h0, 4'h0, mon.remaining_pulses, 3'h0, mon.current_speed};
      if ((a > 8'h03 && a < 8'h26) || (a > 8'h29 && a < 8'h32)) return mem[a[5:0]] & vmask(a);
      if (a > 8'h25 && a < 8'h38) return ro[int'(8'h37 - a) * 8 +: 8] & vmask(a);
      return 8'h00;
   endfunction
   // compare and count
   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask
   // block write of d, image kept in step
   task automatic wblk(input logic [7:0] a);
      for (int i = 0; i < d.size(); i++) begin
         mem[6'(a + i)] = d[i];
      end
      u_pcrm_host.block(a, 1'b1, d, d.size(), q);
   endtask
   // block read compared byte by byte
   task automatic rblk(input logic [7:0] a, input int n);
      u_pcrm_host.block(a, 1'b0, d, n, q);
      for (int i = 0; i < n; i++) begin
         chk(q[i] === {1'b1, expb(8'(a + i))}, "read byte");
      end
   endtask
   // verdict
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // clock and watchdog
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      #100000;
      bad_count++;
      summarize();
   end
   // main sequence
   initial begin
      logic [12:0] spd;
      logic [7:0] a;
      srst = 1'b1;
      ce = 1'b1;
      mon = '0;
      bad_count = 0;
      comparisons = 0;
      mem = '{default: 8'h00};
      void'($urandom(64));
      repeat (8) @(posedge core_clk);
      srst <= 1'b0;
      @(posedge core_clk);
      chk(cfg === '0 && cur_addr === 8'h00 && access_fault === 1'b0, "reset state");
      mon <= '{$urandom, 28'($urandom), 13'($urandom)};
      for (int i = 0; i < 56; i++) begin
         d.push_back(i == 37 ? 8'h00 : 8'($urandom));
      end
      wblk(8'h00);
      chk(access_fault === 1'b1, "fault not set");
      chk(cfg.decel_scurve_range === {mem[12][3:0], mem[13]}, "decel");
      chk(cfg.accel_scurve_range === {mem[14][3:0], mem[15]}, "accel");
      chk(cfg.initial_speed === {mem[25][4:0], mem[26]}, "initial");
      chk(cfg.pulse_count_target === {mem[31][3:0], mem[32], mem[33], mem[34]}, "target");
      rblk(8'h00, 56);
      u_pcrm_host.put('{1'b1, 8'h30, 1'b0, 1'b0, 8'h00});
      u_pcrm_host.idle();
      rblk(8'h32, 4);
      chk(access_fault === 1'b0, "fault not cleared");
      for (int t = 0; t < 40; t++) begin
         a = 8'($urandom_range(0, 55));
         d = {};
         repeat ($urandom_range(1, 8)) d.push_back(8'($urandom));
         mon <= '{$urandom, 28'($urandom), 13'($urandom)};
         wblk(a);
         rblk(a, d.size());
      end
      u_pcrm_host.put('{1'b1, 8'h10, 1'b1, 1'b1, ~mem[16]});
      u_pcrm_host.idle();
      @(posedge core_clk);
      chk(rdata === mem[16] && cur_addr === 8'h11, "write with read");
      mem[16] = ~mem[16];
      ce <= 1'b0;
      u_pcrm_host.put('{1'b1, 8'h10, 1'b1, 1'b0, ~mem[16]});
      u_pcrm_host.idle();
      ce <= 1'b1;
      @(posedge core_clk);
      chk(cfg.decel_rate[15:8] === mem[16] && cur_addr === 8'h11, "frozen");
      for (int k = 0; k < 4; k++) begin
         spd = 13'($urandom);
         a = k[0] ? CMD_RUN_SPEED_A : CMD_RUN_SPEED_B;
         u_pcrm_host.change_speed(spd, a);
         repeat (2) @(posedge core_clk);
         chk(run_speed_sel_b === ~k[0] && active_run_speed === spd, "speed");
         chk(cmd_code === a, "command");
      end
      summarize();
   end
endmodule
